// >>> hw/cor_top.sv
// clock output routing and enable control with serial register port
// Functional notes
// [RL1] select12 high: output 1 from divider 1, output 2 from divider 2
// [RL2] select12 low: outputs 1 and 2 both from divider 2
// [RL3] select36 high: output 3 from divider 3, output 6 from divider 6
// [RL4] select36 low: outputs 3 and 6 both from divider 6
// [RL5] disable mode: low bit 0 tristate, 01 park low, 11 park high
// [RL6] group 0 disable mode affects only output 0
// [RL7] polarity bit 0 passes clock, 1 inverts; group 1 covers outputs 1, 2
// [RL8] group 1 disable mode governs outputs 1 and 2 together
// [RL9] group 3 disable mode governs outputs 3 and 6 together
// [RL10] group 4 disable mode governs output 4 true and complement
// [RL11] group 5 disable mode governs output 5 true and complement
// [RL12] disabled state only while disabled; enabled drives selected clock
`timescale 1ns/1ps
`include "cor_defs.svh"
module cor_top #(
    // arbitrary value, not tied to any part
    parameter logic [6:0] DEV_ADDR = 7'h55
) (
    input  wire logic                     ref_clk,
    input  wire logic                     arst_n,
    input  wire logic                     scl_in,
    input  wire logic                     sda_in,
    output logic                          sda_out_q,
    output logic                          sda_oe_q,
    input  wire logic [6:0]               div_clk,
    input  wire logic [`COR_NUM_PINS-1:0] out_enable,
    output logic      [`COR_NUM_PINS-1:0] clk_out,
    output logic      [`COR_NUM_PINS-1:0] clk_out_oe
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic scl_s;
    logic sda_s;

    cor_sync #(.RST_VAL(1'b1)) u_scl_sync (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .pin_in  (scl_in),
        .level_q (scl_s)
    );

    cor_sync #(.RST_VAL(1'b1)) u_sda_sync (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .pin_in  (sda_in),
        .level_q (sda_s)
    );

    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    cor_pkg::cor_byte_type cfg_q [0:`COR_NUM_REGS-1];

    function automatic logic reg_hit(input logic [7:0] ofs);
        reg_hit = (ofs >= `COR_OFS_GROUP0) && (ofs <= `COR_OFS_GROUP6);
    endfunction

    function automatic logic [2:0] reg_idx(input logic [7:0] ofs);
        logic [7:0] diff;
        diff    = ofs - `COR_OFS_GROUP0;
        reg_idx = diff[2:0];
    endfunction

    function automatic logic [7:0] reg_wmask(input logic [2:0] idx);
        unique case (idx)
            3'h0:    reg_wmask = `COR_WMASK_GROUP0;
            3'h1:    reg_wmask = `COR_WMASK_GROUP1;
            3'h2:    reg_wmask = `COR_WMASK_GROUP2;
            3'h3:    reg_wmask = `COR_WMASK_GROUP3;
            3'h4:    reg_wmask = `COR_WMASK_GROUP4;
            3'h5:    reg_wmask = `COR_WMASK_GROUP5;
            3'h6:    reg_wmask = `COR_WMASK_GROUP6;
            default: reg_wmask = 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] reg_rst(input int idx);
        reg_rst = (idx == 0) ? `COR_RST_GROUP0 : `COR_RST_OTHER;
    endfunction

    // ----------------------------------------------------------------
    // serial port events
    // ----------------------------------------------------------------
    logic scl_p_q;
    logic sda_p_q;
    logic start_w;
    logic stop_w;
    logic rise_w;
    logic fall_w;

    assign start_w = scl_s & scl_p_q & sda_p_q & ~sda_s;
    assign stop_w  = scl_s & scl_p_q & ~sda_p_q & sda_s;
    assign rise_w  = scl_s & ~scl_p_q;
    assign fall_w  = ~scl_s & scl_p_q;

    // ----------------------------------------------------------------
    // serial port state
    // ----------------------------------------------------------------
    cor_pkg::cor_sp_state_type state_q;
    cor_pkg::cor_sp_state_type state_d;
    logic [3:0] bit_q;
    logic [3:0] bit_d;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic [7:0] ptr_q;
    logic [7:0] ptr_d;
    logic [7:0] tx_q;
    logic [7:0] tx_d;
    logic       rw_q;
    logic       rw_d;
    logic       oe_d;
    logic       wr_en;
    logic [7:0] rd_data;
    logic       byte_done;

    assign rd_data   = reg_hit(ptr_q) ? cfg_q[reg_idx(ptr_q)] : 8'h00;
    assign byte_done = fall_w && (bit_q == `COR_BITS_PER_BYTE);

    always_comb begin
        state_d = state_q;
        bit_d   = bit_q;
        shift_d = shift_q;
        ptr_d   = ptr_q;
        tx_d    = tx_q;
        rw_d    = rw_q;
        oe_d    = sda_oe_q;
        wr_en   = 1'b0;
        if (start_w) begin
            state_d = cor_pkg::SP_ADDR;
            bit_d   = 4'h0;
            oe_d    = 1'b0;
        end else if (stop_w) begin
            state_d = cor_pkg::SP_IDLE;
            oe_d    = 1'b0;
        end else begin
            unique case (state_q)
                cor_pkg::SP_IDLE: begin
                end
                cor_pkg::SP_ADDR, cor_pkg::SP_PTR,
                cor_pkg::SP_WDATA: begin
                    if (rise_w && bit_q < `COR_BITS_PER_BYTE) begin
                        shift_d = {shift_q[6:0], sda_s};
                        bit_d   = bit_q + 4'h1;
                    end
                    if (byte_done) begin
                        bit_d = 4'h0;
                        oe_d  = 1'b1;
                        if (state_q == cor_pkg::SP_ADDR) begin
                            rw_d    = shift_q[0];
                            state_d = cor_pkg::SP_ACK_ADDR;
                            if (shift_q[7:1] != DEV_ADDR) begin
                                oe_d    = 1'b0;
                                state_d = cor_pkg::SP_IDLE;
                            end
                        end else if (state_q == cor_pkg::SP_PTR) begin
                            ptr_d   = shift_q;
                            state_d = cor_pkg::SP_ACK_PTR;
                        end else begin
                            wr_en   = 1'b1;
                            state_d = cor_pkg::SP_ACK_WDATA;
                        end
                    end
                end
                cor_pkg::SP_ACK_ADDR: begin
                    if (fall_w) begin
                        if (rw_q) begin
                            tx_d    = rd_data;
                            oe_d    = ~rd_data[7];
                            bit_d   = 4'h1;
                            state_d = cor_pkg::SP_RDATA;
                        end else begin
                            oe_d    = 1'b0;
                            state_d = cor_pkg::SP_PTR;
                        end
                    end
                end
                cor_pkg::SP_ACK_PTR: begin
                    if (fall_w) begin
                        oe_d    = 1'b0;
                        state_d = cor_pkg::SP_WDATA;
                    end
                end
                cor_pkg::SP_ACK_WDATA: begin
                    if (fall_w) begin
                        oe_d    = 1'b0;
                        ptr_d   = ptr_q + 8'h01;
                        state_d = cor_pkg::SP_WDATA;
                    end
                end
                cor_pkg::SP_RDATA: begin
                    if (byte_done) begin
                        oe_d    = 1'b0;
                        state_d = cor_pkg::SP_RACK;
                    end else if (fall_w) begin
                        tx_d  = {tx_q[6:0], 1'b0};
                        oe_d  = ~tx_q[6];
                        bit_d = bit_q + 4'h1;
                    end
                end
                cor_pkg::SP_RACK: begin
                    if (rise_w) begin
                        if (sda_s) begin
                            state_d = cor_pkg::SP_IDLE;
                        end else begin
                            ptr_d = ptr_q + 8'h01;
                        end
                    end else if (fall_w) begin
                        tx_d    = rd_data;
                        oe_d    = ~rd_data[7];
                        bit_d   = 4'h1;
                        state_d = cor_pkg::SP_RDATA;
                    end
                end
                default: begin
                    state_d = cor_pkg::SP_IDLE;
                    oe_d    = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q  <= cor_pkg::SP_IDLE;
            bit_q    <= 4'h0;
            shift_q  <= 8'h00;
            ptr_q    <= 8'h00;
            tx_q     <= 8'h00;
            rw_q     <= 1'b0;
            sda_oe_q <= 1'b0;
            scl_p_q  <= 1'b1;
            sda_p_q  <= 1'b1;
        end else begin
            state_q  <= state_d;
            bit_q    <= bit_d;
            shift_q  <= shift_d;
            ptr_q    <= ptr_d;
            tx_q     <= tx_d;
            rw_q     <= rw_d;
            sda_oe_q <= oe_d;
            scl_p_q  <= scl_s;
            sda_p_q  <= sda_s;
        end
    end

    // open drain: only ever pulls low
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sda_out_q <= 1'b0;
        end else begin
            sda_out_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    logic       wr_hit;
    logic [2:0] wr_idx;
    logic [7:0] wr_val;

    assign wr_hit = wr_en && reg_hit(ptr_q);
    assign wr_idx = reg_idx(ptr_q);
    assign wr_val = shift_q & reg_wmask(wr_idx);

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < `COR_NUM_REGS; i++) begin
                cfg_q[i] <= reg_rst(i);
            end
        end else if (wr_hit) begin
            cfg_q[wr_idx] <= wr_val;
        end
    end

    // ----------------------------------------------------------------
    // routing, polarity and disable mode per pin
    // ----------------------------------------------------------------
    logic                     pair12_source_select;
    logic                     pair36_source_select;
    logic [1:0]               group0_disable_mode;
    logic [1:0]               group1_disable_mode;
    logic [1:0]               group3_disable_mode;
    logic [1:0]               group4_disable_mode;
    logic [1:0]               group5_disable_mode;
    logic                     group0_polarity;
    logic                     group1_polarity;
    logic [`COR_NUM_PINS-1:0] pin_src;
    logic [`COR_NUM_PINS-1:0] pin_inv;
    logic [1:0]               pin_mode [0:`COR_NUM_PINS-1];

    assign pair12_source_select = cfg_q[0][`COR_PAIR12_SEL];
    assign pair36_source_select = cfg_q[0][`COR_PAIR36_SEL];
    assign group0_disable_mode  = cfg_q[0][`COR_MODE_HI:`COR_MODE_LO];
    assign group1_disable_mode  = cfg_q[1][`COR_MODE_HI:`COR_MODE_LO];
    assign group3_disable_mode  = cfg_q[3][`COR_MODE_HI:`COR_MODE_LO];
    assign group4_disable_mode  = cfg_q[4][`COR_MODE_HI:`COR_MODE_LO];
    assign group5_disable_mode  = cfg_q[5][`COR_MODE_HI:`COR_MODE_LO];
    assign group0_polarity      = cfg_q[0][`COR_POL_A];
    assign group1_polarity      = cfg_q[1][`COR_POL_A];

    // pin order: 0,1,2,3,4,4 complement,5,5 complement,6
    assign pin_src[0] = div_clk[0];
    assign pin_src[1] = pair12_source_select ? div_clk[1]   // RL1
                                             : div_clk[2];  // RL2
    assign pin_src[2] = div_clk[2];                         // RL1 RL2
    assign pin_src[3] = pair36_source_select ? div_clk[3]   // RL3
                                             : div_clk[6];  // RL4
    assign pin_src[4] = div_clk[4];
    assign pin_src[5] = ~div_clk[4];
    assign pin_src[6] = div_clk[5];
    assign pin_src[7] = ~div_clk[5];
    assign pin_src[8] = div_clk[6];                         // RL3 RL4

    assign pin_inv[0] = group0_polarity;                    // RL7
    assign pin_inv[1] = group1_polarity;                    // RL7
    assign pin_inv[2] = group1_polarity;                    // RL7
    assign pin_inv[3] = cfg_q[3][`COR_POL_A];
    assign pin_inv[4] = cfg_q[4][`COR_POL_A];
    assign pin_inv[5] = cfg_q[4][`COR_POL_A];
    assign pin_inv[6] = cfg_q[5][`COR_POL_A];
    assign pin_inv[7] = cfg_q[5][`COR_POL_A];
    assign pin_inv[8] = cfg_q[3][`COR_POL_B];

    assign pin_mode[0] = group0_disable_mode;               // RL6
    assign pin_mode[1] = group1_disable_mode;               // RL8
    assign pin_mode[2] = group1_disable_mode;               // RL8
    assign pin_mode[3] = group3_disable_mode;               // RL9
    assign pin_mode[4] = group4_disable_mode;               // RL10
    assign pin_mode[5] = group4_disable_mode;               // RL10
    assign pin_mode[6] = group5_disable_mode;               // RL11
    assign pin_mode[7] = group5_disable_mode;               // RL11
    assign pin_mode[8] = group3_disable_mode;               // RL9

    // ----------------------------------------------------------------
    // output pins
    // ----------------------------------------------------------------
    for (genvar p = 0; p < `COR_NUM_PINS; p++) begin : g_pin
        cor_out_stage u_stage (
            .ref_clk  (ref_clk),
            .arst_n   (arst_n),
            .src_clk  (pin_src[p]),
            .invert   (pin_inv[p]),
            .enable   (out_enable[p]),
            .mode     (pin_mode[p]),
            .pin_q    (clk_out[p]),
            .pin_oe_q (clk_out_oe[p])
        );
    end

endmodule

// >>> include/cor_defs.svh
// register offsets, field positions, reset values and write masks
`ifndef COR_DEFS_SVH
`define COR_DEFS_SVH

// --------------------------------------------------------------------
// register offsets
// --------------------------------------------------------------------
`define COR_OFS_GROUP0       8'h75
`define COR_OFS_GROUP1       8'h76
`define COR_OFS_GROUP2       8'h77
`define COR_OFS_GROUP3       8'h78
`define COR_OFS_GROUP4       8'h79
`define COR_OFS_GROUP5       8'h7A
`define COR_OFS_GROUP6       8'h7B
`define COR_NUM_REGS         7

// --------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------
`define COR_MODE_HI          7
`define COR_MODE_LO          6
`define COR_POL_A            3
`define COR_POL_B            2
`define COR_PAIR12_SEL       1
`define COR_PAIR36_SEL       0

// --------------------------------------------------------------------
// reset values
// --------------------------------------------------------------------
`define COR_RST_GROUP0       8'h03
`define COR_RST_OTHER        8'h00

// --------------------------------------------------------------------
// writable bits; reserved bits read as zero
// --------------------------------------------------------------------
`define COR_WMASK_GROUP0     8'hFB
`define COR_WMASK_GROUP1     8'hF8
`define COR_WMASK_GROUP2     8'h30
`define COR_WMASK_GROUP3     8'hFC
`define COR_WMASK_GROUP4     8'hF8
`define COR_WMASK_GROUP5     8'hF8
`define COR_WMASK_GROUP6     8'h30

// --------------------------------------------------------------------
// serial port and output pin count
// --------------------------------------------------------------------
`define COR_BITS_PER_BYTE    4'h8
`define COR_NUM_PINS         9

`endif

// >>> include/cor_pkg.sv
// types shared by the output routing and control block
package cor_pkg;

    typedef enum logic [3:0] {
        SP_IDLE,
        SP_ADDR,
        SP_ACK_ADDR,
        SP_PTR,
        SP_ACK_PTR,
        SP_WDATA,
        SP_ACK_WDATA,
        SP_RDATA,
        SP_RACK
    } cor_sp_state_type;

    typedef logic [7:0] cor_byte_type;

endpackage

// >>> hw/cor_sync.sv
// two flip-flop synchroniser for one pin level
`timescale 1ns/1ps
module cor_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic ref_clk,
    input  wire logic arst_n,
    input  wire logic pin_in,
    output logic      level_q
);

    logic meta_q;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q  <= RST_VAL;
            level_q <= RST_VAL;
        end else begin
            meta_q  <= pin_in;
            level_q <= meta_q;
        end
    end

endmodule

// >>> hw/cor_out_stage.sv
// one clock output pin: polarity, enable and disabled-state drive
`timescale 1ns/1ps
module cor_out_stage (
    input  wire logic       ref_clk,
    input  wire logic       arst_n,
    input  wire logic       src_clk,
    input  wire logic       invert,
    input  wire logic       enable,
    input  wire logic [1:0] mode,
    output logic            pin_q,
    output logic            pin_oe_q
);

    logic pin_d;
    logic oe_d;

    // ----------------------------------------------------------------
    // drive selection
    // ----------------------------------------------------------------
    assign pin_d = enable ? (src_clk ^ invert)             // RL7 RL12
                 : (mode[0] & mode[1]);                    // RL5
    assign oe_d  = enable | mode[0];                       // RL5 RL12

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_q    <= 1'b0;
            pin_oe_q <= 1'b0;
        end else begin
            pin_q    <= pin_d;
            pin_oe_q <= oe_d;
        end
    end

endmodule

// >>> test/cor_host_model.sv
// serial host driving the register port lines
`timescale 1ns/1ps
module cor_host_model #(
    parameter int PH = 5
) (
    input  wire logic ref_clk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_drv
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic wait_ph();
        repeat (PH) @(negedge ref_clk);
    endtask
    // also a repeated start
    task automatic start();
        sda_drv = 1'b1;
        wait_ph();
        scl = 1'b1;
        wait_ph();
        sda_drv = 1'b0;
        wait_ph();
        scl = 1'b0;
        wait_ph();
    endtask
    task automatic stop();
        sda_drv = 1'b0;
        wait_ph();
        scl = 1'b1;
        wait_ph();
        sda_drv = 1'b1;
        wait_ph();
    endtask
    // data set with clock low, read at end of high
    task automatic clk_bit(input logic b, output logic r);
        sda_drv = b;
        wait_ph();
        scl = 1'b1;
        wait_ph();
        r = sda_line;
        scl = 1'b0;
        wait_ph();
    endtask
    task automatic byte_out(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], r);
        end
        clk_bit(1'b1, r);
        ack = ~r;
    endtask
    // last byte answered with a release
    task automatic byte_in(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, d[i]);
        end
        clk_bit(last, r);
    endtask
endmodule

// >>> test/cor_monitor.sv
// concurrent checks on the routing block pins
`timescale 1ns/1ps
module cor_monitor (
    input wire logic       ref_clk,
    input wire logic       arst_n,
    input wire logic       sda_out_q,
    input wire logic       sda_oe_q,
    input wire logic [6:0] div_clk,
    input wire logic [8:0] out_enable,
    input wire logic [8:0] clk_out,
    input wire logic [8:0] clk_out_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    // ----------------------------------------
    // sequences and properties
    // ----------------------------------------
    sequence s_both_on(ea, eb);
        ea && eb;
    endsequence
    sequence s_both_off(ea, eb);
        !ea && !eb;
    endsequence
    property p_complement(ea, eb, pa, pb);
        s_both_on(ea, eb) |=> (pa != pb);
    endproperty
    property p_shared_mode(ea, eb, pa, pb, oa, ob);
        s_both_off(ea, eb) |=> (pa == pb) && (oa == ob);
    endproperty

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    AST_ENABLED_DRIVEN: assert property (1'b1 |=>
        ((clk_out_oe | ~$past(out_enable)) == '1))
        else $error("enabled clock pin not driven");
    AST_TRISTATE_ZERO: assert property ((clk_out & ~clk_out_oe) == '0)
        else $error("undriven clock pin shows high value");
    AST_PAIR4_COMPLEMENT: assert property (p_complement(
        out_enable[4], out_enable[5], clk_out[4], clk_out[5]))
        else $error("output 4 pair not complementary");
    AST_PAIR5_COMPLEMENT: assert property (p_complement(
        out_enable[6], out_enable[7], clk_out[6], clk_out[7]))
        else $error("output 5 pair not complementary");
    AST_GROUP1_SHARED: assert property (p_shared_mode(out_enable[1],
        out_enable[2], clk_out[1], clk_out[2], clk_out_oe[1],
        clk_out_oe[2])) else $error("outputs 1 and 2 disabled apart");
    AST_GROUP3_SHARED: assert property (p_shared_mode(out_enable[3],
        out_enable[8], clk_out[3], clk_out[8], clk_out_oe[3],
        clk_out_oe[8])) else $error("outputs 3 and 6 disabled apart");
    AST_GROUP4_SHARED: assert property (p_shared_mode(out_enable[4],
        out_enable[5], clk_out[4], clk_out[5], clk_out_oe[4],
        clk_out_oe[5])) else $error("output 4 pair disabled apart");
    AST_GROUP5_SHARED: assert property (p_shared_mode(out_enable[6],
        out_enable[7], clk_out[6], clk_out[7], clk_out_oe[6],
        clk_out_oe[7])) else $error("output 5 pair disabled apart");
    AST_PAIR12_ROUTE: assert property (s_both_on(out_enable[1],
        out_enable[2]) |=> ((clk_out[1] ^ clk_out[2]) == 1'b0) ||
        ((clk_out[1] ^ clk_out[2]) == $past(div_clk[1] ^ div_clk[2])))
        else $error("outputs 1 and 2 from no legal divider");
    AST_SDA_OPEN_DRAIN: assert property (sda_oe_q |-> !sda_out_q)
        else $error("data pin driven high");
endmodule

// >>> test/cor_top_test.sv
// self-checking bench for the routing block
`timescale 1ns/1ps
module cor_top_test;
    localparam logic [6:0] DEV = 7'h55;
    logic       ref_clk;
    logic       arst_n;
    logic [6:0] div_clk;
    logic [8:0] out_enable;
    logic [8:0] clk_out;
    logic [8:0] clk_out_oe;
    logic       sda_out_q;
    logic       sda_oe_q;
    logic       scl;
    logic       sda_drv;
    logic       sda_line;
    int         mismatches = 0;
    int         total_checks = 0;
    int         cycles = 0;
    logic [7:0] rbuf [8];
    logic [7:0] wbuf [8];

    // pulled-up data line
    assign sda_line = sda_drv & ~(sda_oe_q & ~sda_out_q);

    cor_top #(.DEV_ADDR(DEV)) dut (.ref_clk(ref_clk), .arst_n(arst_n),
        .scl_in(scl), .sda_in(sda_line), .sda_out_q(sda_out_q),
        .sda_oe_q(sda_oe_q), .div_clk(div_clk), .out_enable(out_enable),
        .clk_out(clk_out), .clk_out_oe(clk_out_oe));
    cor_host_model host (.ref_clk(ref_clk), .sda_line(sda_line),
        .scl(scl), .sda_drv(sda_drv));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            mismatches++;
            test_done();
        end
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic fill(input logic [7:0] v);
        for (int i = 0; i < 8; i++) begin
            wbuf[i] = v;
        end
    endtask
    task automatic wr_regs(input logic [7:0] ofs, input int n);
        logic a;
        host.start();
        host.byte_out({DEV, 1'b0}, a);
        check({8'h00, a}, 9'h001);
        host.byte_out(ofs, a);
        for (int i = 0; i < n; i++) begin
            host.byte_out(wbuf[i], a);
        end
        host.stop();
    endtask
    task automatic rd_regs(input logic [7:0] ofs, input int n);
        logic a;
        host.start();
        host.byte_out({DEV, 1'b0}, a);
        host.byte_out(ofs, a);
        host.start();
        host.byte_out({DEV, 1'b1}, a);
        for (int i = 0; i < n; i++) begin
            host.byte_in(i == n - 1, rbuf[i]);
        end
        host.stop();
    endtask
    task automatic pins(input logic [8:0] eo, input logic [8:0] ee);
        repeat (2) @(negedge ref_clk);
        check(clk_out, eo);
        check(clk_out_oe, ee);
    endtask
    // enabled pins with groups 3 to 5 uninverted
    function automatic logic [8:0] route(input logic s12, input logic s36,
        input logic p0, input logic p1, input logic [6:0] d);
        logic o1;
        logic o3;
        o1 = (s12 ? d[1] : d[2]) ^ p1;
        o3 = s36 ? d[3] : d[6];
        return {d[6], ~d[5], d[5], ~d[4], d[4], o3, d[2] ^ p1, o1, d[0] ^ p0};
    endfunction

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset_values();
        rd_regs(8'h74, 8);
        check({1'b0, rbuf[0]}, 9'h000);
        check({1'b0, rbuf[1]}, 9'h003);
        for (int i = 2; i < 8; i++) begin
            check({1'b0, rbuf[i]}, 9'h000);
        end
    endtask
    task automatic t_access();
        logic [7:0] exp [8] = '{8'h00, 8'hFB, 8'hF8, 8'h30, 8'hFC, 8'hF8,
            8'hF8, 8'h30};
        logic a;
        fill(8'hFF);
        wr_regs(8'h74, 8);
        rd_regs(8'h74, 8);
        for (int i = 0; i < 8; i++) begin
            check({1'b0, rbuf[i]}, {1'b0, exp[i]});
        end
        host.start();
        host.byte_out({~DEV, 1'b0}, a);
        host.stop();
        check({8'h00, a}, 9'h000);
        fill(8'h00);
        wbuf[0] = 8'h03;
        wr_regs(8'h75, 7);
    endtask
    task automatic t_routing();
        out_enable = '1;
        for (int k = 0; k < 4; k++) begin
            wbuf[0] = {6'h00, k[1:0]};
            wr_regs(8'h75, 1);
            for (int j = 0; j < 2; j++) begin
                div_clk = j ? 7'h75 : 7'h0A;
                pins(route(k[1], k[0], 1'b0, 1'b0, div_clk),
                    '1);
            end
        end
    endtask
    task automatic t_polarity();
        wbuf[0] = 8'h0B;
        wbuf[1] = 8'h08;
        wbuf[3] = 8'h0C;
        wbuf[4] = 8'h08;
        wbuf[5] = 8'h08;
        wr_regs(8'h75, 6);
        for (int j = 0; j < 2; j++) begin
            div_clk = j ? 7'h75 : 7'h0A;
            pins(route(1'b1, 1'b1, 1'b1, 1'b1, div_clk) ^ 9'h1F8, '1);
        end
    endtask
    task automatic t_groups();
        logic [8:0] msk [5] = '{9'h001, 9'h006, 9'h108, 9'h030, 9'h0C0};
        int pos [5] = '{0, 1, 3, 4, 5};
        out_enable = '0;
        for (int g = 0; g < 5; g++) begin
            fill(8'h00);
            wbuf[0] = 8'h03;
            wbuf[pos[g]] = wbuf[pos[g]] | 8'hC0;
            wr_regs(8'h75, 6);
            pins(msk[g], msk[g]);
        end
        out_enable = '1;
        div_clk = 7'h0A;
        pins(route(1'b1, 1'b1, 1'b0, 1'b0, div_clk), 9'h1FF);
    endtask
    task automatic t_modes();
        out_enable = '0;
        for (int m = 0; m < 4; m++) begin
            fill({m[1:0], 6'h00});
            wbuf[0][1:0] = 2'h3;
            wr_regs(8'h75, 6);
            pins({9{m == 3}}, {9{m[0]}});
        end
    endtask

    initial begin
        arst_n = 1'b0;
        div_clk = 7'h00;
        out_enable = '1;
        repeat (5) @(negedge ref_clk);
        arst_n = 1'b1;
        repeat (8) @(negedge ref_clk);
        t_reset_values();
        t_access();
        t_routing();
        t_polarity();
        t_groups();
        t_modes();
        test_done();
    end
endmodule

bind cor_top cor_monitor u_mon (.ref_clk(ref_clk), .arst_n(arst_n),
    .sda_out_q(sda_out_q), .sda_oe_q(sda_oe_q), .div_clk(div_clk),
    .out_enable(out_enable), .clk_out(clk_out), .clk_out_oe(clk_out_oe));
